// [core/misc_skip_defines.vh]
`ifndef MISC_SKIP_DEFINES_VH
`define MISC_SKIP_DEFINES_VH
`define OP_SKIP_T3        10'h282
`define OP_SOFT_RESET     10'h001
`define OP_SET_TABLE_HIGH 10'h059
`define OP_VDET_PD        10'h293
`define T3_EN_BIT         0
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_IRQ_STAT      8'h08
`define REG_IRQ_MASK      8'h0C
`define ST_SKIP_BIT       0
`define ST_T3CLR_BIT      1
`define ST_SOFTWARE_SYSTEM_RESET_BIT       2
`define ST_UPT_BIT        3
`define ST_VDET_BIT       4
`define IRQ_W             5
`define CTRL_RESET_VAL    4'h0
`endif

// [core/misc_opcode_decode.v]
`include "misc_skip_defines.vh"
module misc_opcode_decode (
  input  wire [9:0] opcode_in,
  input  wire       valid_in,
  output wire       is_skip_t3_out,
  output wire       is_soft_reset_out,
  output wire       is_set_table_out,
  output wire       is_vdet_out
);
  assign is_skip_t3_out    = valid_in && (opcode_in == `OP_SKIP_T3);
  assign is_soft_reset_out = valid_in && (opcode_in == `OP_SOFT_RESET);
  assign is_set_table_out  = valid_in && (opcode_in == `OP_SET_TABLE_HIGH);
  assign is_vdet_out       = valid_in && (opcode_in == `OP_VDET_PD);
endmodule

// [core/misc_flag_skip.v]
// Function
// - The timer-3 skip is decoded from opcode 1010000010, one word, one cycle.
// - With the enable bit 0, it skips the next instruction when the timer-3 flag is 1.
// - With the enable bit 0, it also clears the timer-3 request flag.
// - With the enable bit 1, it is a no-operation: no skip, flag untouched.
// - The gating bit is bit 0 of the interrupt control register.
// - Opcode 0001011001 sets the table high-bit enable flag to 1.
// - Opcode 1010010011 sets the flag keeping the voltage detector active in powerdown.
//
// Chosen here: the address map and the AHB-Lite slave port.
`include "misc_skip_defines.vh"
module misc_flag_skip (
  input  wire        CLK_IN,
  input  wire        RST_B_IN,
  input  wire [9:0]  OPCODE_IN,
  input  wire        OP_VALID_IN,
  input  wire        T3_FLAG_IN,
  input  wire [31:0] HADDR_IN,
  input  wire [1:0]  HTRANS_IN,
  input  wire        HWRITE_IN,
  input  wire [2:0]  HSIZE_IN,
  input  wire        HSEL_IN,
  input  wire        HREADY_IN,
  input  wire [31:0] HWDATA_IN,
  output reg  [31:0] HRDATA_OUT,
  output reg         HREADYOUT_OUT,
  output reg         HRESP_OUT,
  output reg         SKIP_NEXT_OUT,
  output reg         T3_FLAG_CLEAR_OUT,
  output reg         SYS_RESET_OUT,
  output reg         TABLE_HIGH_FLAG_OUT,
  output reg         VDET_PD_FLAG_OUT,
  output reg         IRQ_OUT
);
  wire is_skip;
  wire is_software_system_reset;
  wire is_upt;
  wire is_vdet;
  reg  [3:0]  ctrl_q;
  reg  [`IRQ_W-1:0] stat_q;
  reg  [`IRQ_W-1:0] mask_q;
  reg         wr_pend_q;
  reg         rd_stat_q;
  reg  [7:0]  addr_q;
  wire        gate;
  wire        skip_now;
  wire        clr_now;
  wire [`IRQ_W-1:0] events;
  wire        acc;
  reg  [31:0] rdata_d;

  misc_opcode_decode u_dec (
    .opcode_in         (OPCODE_IN),
    .valid_in          (OP_VALID_IN),
    .is_skip_t3_out    (is_skip),
    .is_soft_reset_out (is_software_system_reset),
    .is_set_table_out  (is_upt),
    .is_vdet_out       (is_vdet)
  );

  // Flag comes from the core's own clock domain, no synchroniser needed
  assign gate     = ctrl_q[`T3_EN_BIT];
  assign skip_now = is_skip && !gate && T3_FLAG_IN;
  assign clr_now  = is_skip && !gate;
  assign events   = {is_vdet, is_upt, is_software_system_reset, clr_now, skip_now};
  assign acc      = HSEL_IN && HREADY_IN && HTRANS_IN[1];

  always @* begin
    rdata_d = 32'h0000_0000;
    case (HADDR_IN[7:0])
      `REG_CTRL:     rdata_d = {28'h000_0000, ctrl_q};
      `REG_STATUS:   rdata_d = {30'h0000_0000, VDET_PD_FLAG_OUT, TABLE_HIGH_FLAG_OUT};
      `REG_IRQ_STAT: rdata_d = {27'h000_0000, stat_q};
      `REG_IRQ_MASK: rdata_d = {27'h000_0000, mask_q};
      default:       rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      ctrl_q              <= `CTRL_RESET_VAL;
      stat_q              <= 5'h00;
      mask_q              <= 5'h00;
      wr_pend_q           <= 1'b0;
      rd_stat_q           <= 1'b0;
      addr_q              <= 8'h00;
      HRDATA_OUT          <= 32'h0000_0000;
      HREADYOUT_OUT       <= 1'b1;
      HRESP_OUT           <= 1'b0;
      SKIP_NEXT_OUT       <= 1'b0;
      T3_FLAG_CLEAR_OUT   <= 1'b0;
      SYS_RESET_OUT       <= 1'b0;
      TABLE_HIGH_FLAG_OUT <= 1'b0;
      VDET_PD_FLAG_OUT    <= 1'b0;
      IRQ_OUT             <= 1'b0;
    end else begin
      SKIP_NEXT_OUT     <= skip_now;
      T3_FLAG_CLEAR_OUT <= clr_now;
      // Pulse fed back to core reset; the flags here stay, only core state resets
      SYS_RESET_OUT     <= is_software_system_reset;
      if (is_upt)
        TABLE_HIGH_FLAG_OUT <= 1'b1;
      if (is_vdet)
        VDET_PD_FLAG_OUT <= 1'b1;
      wr_pend_q <= acc && HWRITE_IN;
      rd_stat_q <= acc && !HWRITE_IN && (HADDR_IN[7:0] == `REG_IRQ_STAT);
      addr_q    <= HADDR_IN[7:0];
      if (acc && !HWRITE_IN)
        HRDATA_OUT <= rdata_d;
      if (wr_pend_q && addr_q == `REG_CTRL)
        ctrl_q <= HWDATA_IN[3:0];
      if (wr_pend_q && addr_q == `REG_IRQ_MASK)
        mask_q <= HWDATA_IN[`IRQ_W-1:0];
      // New events win over the read-clear
      stat_q  <= (rd_stat_q ? 5'h00 : stat_q) | events;
      IRQ_OUT <= |(((rd_stat_q ? 5'h00 : stat_q) | events) & mask_q);
    end
  end
endmodule

// [tb/misc_flag_skip_asserts.sv]
`include "misc_skip_defines.vh"
module misc_flag_skip_chk (
  input wire logic       CLK_IN, RST_B_IN, OP_VALID_IN, T3_FLAG_IN, SKIP_NEXT_OUT,
  input wire logic       T3_FLAG_CLEAR_OUT, SYS_RESET_OUT, TABLE_HIGH_FLAG_OUT, VDET_PD_FLAG_OUT,
  input wire logic [9:0] OPCODE_IN
);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  wire k = OP_VALID_IN && OPCODE_IN == `OP_SKIP_T3, r = OP_VALID_IN && OPCODE_IN == `OP_SOFT_RESET;
  wire t = OP_VALID_IN && OPCODE_IN == `OP_SET_TABLE_HIGH, d = OP_VALID_IN && OPCODE_IN == `OP_VDET_PD;
  a_skip_src: assert property (SKIP_NEXT_OUT |-> $past(k && T3_FLAG_IN)) else $error("skip");
  a_clear_src: assert property (T3_FLAG_CLEAR_OUT |-> $past(k)) else $error("clear");
  a_skip_clears: assert property (SKIP_NEXT_OUT |-> T3_FLAG_CLEAR_OUT) else $error("gate");
  a_other_quiet: assert property (OP_VALID_IN && !k |=> !T3_FLAG_CLEAR_OUT) else $error("op");
  a_reset_pulse: assert property (r |=> SYS_RESET_OUT && !SKIP_NEXT_OUT) else $error("software_system_reset");
  a_reset_src: assert property (SYS_RESET_OUT |-> $past(r)) else $error("software_system_reset src");
  a_table_set: assert property (t |=> TABLE_HIGH_FLAG_OUT [*3]) else $error("table");
  a_vdet_set: assert property (d |=> VDET_PD_FLAG_OUT ##1 $stable(VDET_PD_FLAG_OUT)) else $error("vdet");
  cover property (SKIP_NEXT_OUT);
  cover property (T3_FLAG_CLEAR_OUT && !SKIP_NEXT_OUT);
  cover property (SYS_RESET_OUT);
endmodule
bind misc_flag_skip misc_flag_skip_chk misc_flag_skip_chk_i (.*);

// [tb/t3_flag_model.sv]
module t3_flag_model (
  input  wire logic clk_in, rst_b_in, tick_in, clr_in,
  output logic      flag_out = 0
);
  timeunit 1ns; timeprecision 1ns;
  // Clear beats a same-cycle tick, so a lost event shows up as a missed skip
  always @(posedge clk_in) flag_out <= rst_b_in && !clr_in && (flag_out || tick_in);
endmodule

// [tb/misc_flag_skip_bench.sv]
`include "misc_skip_defines.vh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module misc_flag_skip_bench;
  timeunit 1ns; timeprecision 1ns;
  logic CLK_IN = 0, RST_B_IN = 0, OP_VALID_IN = 0, HWRITE_IN = 0, HSEL_IN = 0, tick = 0, en = 0;
  logic [9:0]  OPCODE_IN = 0, ops[4] = '{`OP_SKIP_T3, `OP_SOFT_RESET, `OP_SET_TABLE_HIGH, `OP_VDET_PD};
  logic [1:0]  HTRANS_IN = 0;
  logic [2:0]  HSIZE_IN = 3'h2, q[$], e;
  logic [4:0]  ist = 0;
  logic [31:0] HADDR_IN = 0, HWDATA_IN = 0, r;
  wire  [31:0] HRDATA_OUT;
  wire T3_FLAG_IN, HREADYOUT_OUT, HRESP_OUT, SKIP_NEXT_OUT, T3_FLAG_CLEAR_OUT, SYS_RESET_OUT;
  wire TABLE_HIGH_FLAG_OUT, VDET_PD_FLAG_OUT, IRQ_OUT, HREADY_IN = HREADYOUT_OUT;
  int error_cnt = 0, cmp_count = 0;
  always #20 CLK_IN = !CLK_IN;
  t3_flag_model t3_flag_model_i (.clk_in(CLK_IN), .rst_b_in(RST_B_IN), .tick_in(tick),
    .clr_in(T3_FLAG_CLEAR_OUT), .flag_out(T3_FLAG_IN));
  misc_flag_skip misc_flag_skip_i (.*);
  always @(negedge CLK_IN) if (q.size()) begin
    e = q.pop_front();
    `CHK("pulses", e, {SYS_RESET_OUT, T3_FLAG_CLEAR_OUT, SKIP_NEXT_OUT})
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_IN) {HSEL_IN, HTRANS_IN, HWRITE_IN, HADDR_IN} <= {3'h6, w, 24'h0, a};
    do @(posedge CLK_IN); while (!HREADYOUT_OUT);
    {HSEL_IN, HTRANS_IN, HWDATA_IN} <= {3'h0, d};
    do @(posedge CLK_IN); while (!HREADYOUT_OUT);
    r = HRDATA_OUT;
  endtask
  task automatic run(input logic [9:0] o);
    logic [2:0] x;
    @(posedge CLK_IN) {OPCODE_IN, OP_VALID_IN} <= {o, 1'b1};
    #1 x = {o == `OP_SOFT_RESET, o == `OP_SKIP_T3 && !en, o == `OP_SKIP_T3 && !en && T3_FLAG_IN};
    ist |= {o == `OP_VDET_PD, o == `OP_SET_TABLE_HIGH, x};
    @(posedge CLK_IN) OP_VALID_IN <= 0;
    q.push_back(x);
  endtask
  task automatic stop_test;
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #50000 error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h7593));
    repeat (12) @(posedge CLK_IN);
    RST_B_IN <= 1;
    bus(1, `REG_IRQ_MASK, 32'h1F);
    @(posedge CLK_IN) tick <= 1;
    @(posedge CLK_IN) tick <= 0;
    repeat (2) run(`OP_SKIP_T3);
    @(posedge CLK_IN) tick <= 1;
    @(posedge CLK_IN) tick <= 0;
    bus(1, `REG_CTRL, 32'h1);
    en = 1;
    run(`OP_SKIP_T3);
    repeat (2) @(posedge CLK_IN);
    `CHK("flag", 1'b1, T3_FLAG_IN)
    bus(1, `REG_CTRL, 32'h0);
    en = 0;
    foreach (ops[i]) run(ops[i]);
    repeat (6) run(10'($urandom));
    repeat (2) @(posedge CLK_IN);
    `CHK("irq", 1'b1, IRQ_OUT)
    bus(0, `REG_STATUS, 0);
    `CHK("status", 32'h3, r)
    bus(0, `REG_IRQ_STAT, 0);
    `CHK("events", {27'h0, ist}, r)
    bus(0, 8'h40, 0);
    `CHK("unmapped", 32'h0, r)
    `CHK("irq", 1'b0, IRQ_OUT)
    stop_test();
  end
endmodule
